// ===== rtl/half_signed_load_shift_exec.sv
/*
  Sequencer that executes the halfword/signed load and logical shift group:
  decodes, reads registers, issues one memory read for loads, writes the
  result back and updates N, Z and C for shifts outside a predicated group.
  Assumes register read data follow the read indices in the same cycle and
  that the memory port answers each one-cycle request with one mem_rvalid.
*/
`timescale 1ns/1ns
`include "hsl_cfg.svh"

module half_signed_load_shift_exec
  import hsl_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // instruction stream
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr,
  input  wire logic              in_predicated_group,
  output logic                   instr_ready,
  output logic                   copy_redirect,
  output logic                   not_in_group,
  // register file read
  output logic      [2:0]        rf_rd_a_idx,
  output logic      [2:0]        rf_rd_b_idx,
  input  wire logic [31:0]       rf_rd_a_data,
  input  wire logic [31:0]       rf_rd_b_data,
  // register file write
  output logic                   rf_wr_en,
  output logic      [2:0]        rf_wr_idx,
  output logic      [31:0]       rf_wr_data,
  // status flags
  input  wire logic              carry_now,
  output logic                   flags_wr_en,
  output hsl_pkg::flags_t        status_flags,
  // data memory read port
  output logic                   mem_req,
  output hsl_pkg::mem_req_t      mem_cmd,
  input  wire logic              mem_rvalid,
  input  wire logic [15:0]       mem_rdata
);

  // --------------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------------
  if (DATA_W != 32)
  begin : g_width_check
    $error("half_signed_load_shift_exec supports only a 32-bit data path");
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic is_load(input op_t op);
    is_load = (op == OP_LDH_U_REG) || (op == OP_LDB_S) ||
              (op == OP_LDH_S) || (op == OP_LDH_U_IMM);
  endfunction : is_load

  function automatic logic is_shift(input op_t op);
    is_shift = (op == OP_SHL_IMM) || (op == OP_SHR_IMM) ||
               (op == OP_SHL_REG) || (op == OP_SHR_REG);
  endfunction : is_shift

  function automatic logic [31:0] extend(input op_t op, input logic [15:0] data);
    case (op)
      OP_LDB_S: extend = {{24{data[`BYTE_SIGN]}}, data[`BYTE_BITS]};
      OP_LDH_S: extend = {{16{data[`HALF_SIGN]}}, data};
      default:  extend = {16'h0000, data};
    endcase
  endfunction : extend

  // --------------------------------------------------------------------------
  // decode and shifter
  // --------------------------------------------------------------------------
  state_t      state;
  state_t      next_state;
  dec_t        dec_now;
  dec_t        dec_q;
  logic        pred_q;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [7:0]  sh_count;
  logic [31:0] sh_result;
  logic        sh_carry;
  logic [31:0] next_addr;
  logic        accept;

  assign accept = instr_valid && instr_ready;

  instr_group_decoder u_decoder (
    .instr (instr),
    .dec   (dec_now)
  );

  always_comb
  begin
    case (dec_q.op)
      OP_SHL_IMM: sh_count = {`COUNT_PAD, dec_q.imm};
      OP_SHR_IMM: sh_count = (dec_q.imm == `IMM_ZERO) ? `COUNT_32
                                                      : {`COUNT_PAD, dec_q.imm};
      OP_SHL_REG: sh_count = rf_rd_b_data[`AMOUNT_BITS];
      OP_SHR_REG: sh_count = rf_rd_b_data[`AMOUNT_BITS];
      default:    sh_count = `COUNT_ZERO;
    endcase
  end

  logical_shifter u_shifter (
    .value    (rf_rd_a_data),
    .count    (sh_count),
    .right    ((dec_q.op == OP_SHR_IMM) || (dec_q.op == OP_SHR_REG)),
    .carry_in (carry_now),
    .result   (sh_result),
    .carry    (sh_carry)
  );

  // register offset is added as it stands, immediate offset is doubled first; no base update
  always_comb
  begin
    if (dec_q.op == OP_LDH_U_IMM)
      next_addr = rf_rd_a_data + {`HALF_IMM_PAD, dec_q.imm, 1'b0};
    else
      next_addr = rf_rd_a_data + rf_rd_b_data;
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (accept && (is_load(dec_now.op) || is_shift(dec_now.op)))
          next_state = S_FETCH;
      S_FETCH:
        next_state = is_load(dec_q.op) ? S_MEM : S_IDLE;
      S_MEM:
        if (mem_rvalid)
          next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state       <= S_IDLE;
      instr_ready <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      instr_ready <= (next_state == S_IDLE);
    end
  end

  // instructions this block does not execute are handed back in one cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      copy_redirect <= 1'b0;
      not_in_group  <= 1'b0;
    end
    else
    begin
      copy_redirect <= accept && (dec_now.op == OP_REGISTER_COPY);
      not_in_group  <= accept && (dec_now.op == OP_NONE);
    end
  end

  // --------------------------------------------------------------------------
  // operand capture
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dec_q       <= '0;
      pred_q      <= 1'b0;
      rf_rd_a_idx <= `IDX_ZERO;
      rf_rd_b_idx <= `IDX_ZERO;
    end
    else if (accept)
    begin
      dec_q       <= dec_now;
      pred_q      <= in_predicated_group;
      rf_rd_a_idx <= dec_now.src_a;
      rf_rd_b_idx <= dec_now.src_b;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      opa <= `WORD_ZERO;
      opb <= `WORD_ZERO;
    end
    else if (state == S_FETCH)
    begin
      opa <= rf_rd_a_data;
      opb <= rf_rd_b_data;
    end
  end

  // --------------------------------------------------------------------------
  // memory request
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mem_req      <= 1'b0;
      mem_cmd.addr <= `WORD_ZERO;
      mem_cmd.size <= `SIZE_NONE;
    end
    else
    begin
      mem_req <= (state == S_FETCH) && is_load(dec_q.op);
      if (state == S_FETCH && is_load(dec_q.op))
      begin
        mem_cmd.addr <= next_addr;
        mem_cmd.size <= (dec_q.op == OP_LDB_S) ? `SIZE_BYTE : `SIZE_HALF;
      end
    end
  end

  // --------------------------------------------------------------------------
  // write back and flags
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rf_wr_en   <= 1'b0;
      rf_wr_idx  <= `IDX_ZERO;
      rf_wr_data <= `WORD_ZERO;
    end
    else if (state == S_FETCH && is_shift(dec_q.op))
    begin
      rf_wr_en   <= 1'b1;
      rf_wr_idx  <= dec_q.dst;
      rf_wr_data <= sh_result;
    end
    else if (state == S_MEM && mem_rvalid)
    begin
      rf_wr_en   <= 1'b1;
      rf_wr_idx  <= dec_q.dst;
      rf_wr_data <= extend(dec_q.op, mem_rdata);
    end
    else
      rf_wr_en <= 1'b0;
  end

  // V has no port here, so it stays with the core untouched
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flags_wr_en  <= 1'b0;
      status_flags <= '0;
    end
    else
    begin
      flags_wr_en <= (state == S_FETCH) && is_shift(dec_q.op) && !pred_q;
      if (state == S_FETCH && is_shift(dec_q.op))
      begin
        status_flags.n <= sh_result[`WORD_SIGN];
        status_flags.z <= (sh_result == `WORD_ZERO);
        status_flags.c <= sh_carry;
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  reg_addr_sum_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mem_req && (dec_q.op != OP_LDH_U_IMM) |-> mem_cmd.addr == opa + opb)
    else $error("register load address is not base plus offset");

  imm_addr_sum_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mem_req && (dec_q.op == OP_LDH_U_IMM) |->
      mem_cmd.addr == opa + {`HALF_IMM_PAD, dec_q.imm, 1'b0})
    else $error("immediate load address is not base plus doubled immediate");

  half_zero_ext_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mem_rvalid && (state == S_MEM) &&
      (dec_q.op == OP_LDH_U_REG || dec_q.op == OP_LDH_U_IMM) |=>
      rf_wr_en && rf_wr_data == {16'h0000, $past(mem_rdata)})
    else $error("unsigned halfword not zero-extended");

  byte_sign_ext_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && (dec_q.op == OP_LDB_S) |->
      rf_wr_data[31:8] == {24{rf_wr_data[`BYTE_SIGN]}})
    else $error("signed byte not sign-extended");

  half_sign_ext_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && (dec_q.op == OP_LDH_S) |->
      rf_wr_data[31:16] == {16{rf_wr_data[`HALF_SIGN]}})
    else $error("signed halfword not sign-extended");

  copy_handoff_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    accept && (instr[`OPC5_FLD] == `OPC5_SHL_IMM) && (instr[`FLD_FIVE_BIT_IMMEDIATE] == `IMM_ZERO) |=>
      copy_redirect && (state == S_IDLE) ##1 !rf_wr_en)
    else $error("zero left shift was not handed over as a copy");

  shl_imm_result_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && (dec_q.op == OP_SHL_IMM) |-> rf_wr_data == (opa << dec_q.imm))
    else $error("immediate left shift result wrong");

  shr_zero_is_32_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && (dec_q.op == OP_SHR_IMM) && (dec_q.imm == `IMM_ZERO) |->
      rf_wr_data == `WORD_ZERO && status_flags.c == opa[`WORD_SIGN])
    else $error("right shift by zero field did not act as 32");

  shift_latency_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    accept && is_shift(dec_now.op) |-> ##2 (rf_wr_en && rf_wr_idx == dec_q.dst))
    else $error("shift result not written two cycles after accept");

  reg_shift_dest_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    accept && (dec_now.op == OP_SHL_REG || dec_now.op == OP_SHR_REG) |=>
      rf_rd_a_idx == $past(instr[`FLD_LOW]) ##1 rf_wr_idx == rf_rd_a_idx)
    else $error("register shift destination differs from operand");

  amount_low_byte_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && (dec_q.op == OP_SHL_REG || dec_q.op == OP_SHR_REG) &&
      (opb[`AMOUNT_BITS] == `COUNT_ZERO) |-> rf_wr_data == opa)
    else $error("zero low byte of amount changed the value");

  flag_values_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    flags_wr_en |-> rf_wr_en && status_flags.n == rf_wr_data[`WORD_SIGN] &&
      status_flags.z == (rf_wr_data == `WORD_ZERO))
    else $error("N or Z does not match the shift result");

  pred_no_flags_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rf_wr_en && is_shift(dec_q.op) |-> flags_wr_en == !pred_q)
    else $error("flag write does not follow predicated state");

endmodule : half_signed_load_shift_exec

// ===== rtl/hsl_cfg.svh
/*
  Encodings, field slices and fixed values of the halfword/signed load and
  logical shift group. Assumes 16-bit instruction words with bit 15 leftmost.
*/
`ifndef HSL_CFG_SVH
`define HSL_CFG_SVH

// --------------------------------------------------------------------------
// opcode fields
// --------------------------------------------------------------------------
`define OPC7_FLD        15:9
`define OPC5_FLD        15:11
`define OPC10_FLD       15:6
`define OPC7_LDH_U_REG  7'h2D
`define OPC7_LDB_S      7'h2B
`define OPC7_LDH_S      7'h2F
`define OPC5_LDH_U_IMM  5'h11
`define OPC5_SHL_IMM    5'h00
`define OPC5_SHR_IMM    5'h01
`define OPC10_SHL_REG   10'h102
`define OPC10_SHR_REG   10'h103

// --------------------------------------------------------------------------
// operand fields
// --------------------------------------------------------------------------
`define FLD_LOW         2:0
`define FLD_MID         5:3
`define FLD_OFS         8:6
`define FLD_FIVE_BIT_IMMEDIATE        10:6

// --------------------------------------------------------------------------
// fixed values
// --------------------------------------------------------------------------
`define IMM_ZERO        5'h00
`define COUNT_ZERO      8'h00
`define COUNT_PAD       3'h0
`define COUNT_32        8'h20
`define AMOUNT_BITS     7:0
`define HALF_IMM_PAD    26'h0000000
`define BYTE_BITS       7:0
`define BYTE_SIGN       7
`define HALF_SIGN       15
`define WORD_SIGN       31
`define SIZE_BYTE       2'h1
`define SIZE_HALF       2'h2
`define SIZE_NONE       2'h0
`define WORD_ZERO       32'h00000000
`define IDX_ZERO        3'h0

`endif

// ===== rtl/hsl_pkg.sv
/*
  Types shared by the load/shift group: operation codes, decoded fields,
  memory request, flag set and sequencer states. Assumes hsl_cfg.svh beside it.
*/
package hsl_pkg;

  typedef enum logic [3:0] {
    OP_NONE          = 4'b0000,
    OP_LDH_U_REG     = 4'b0001,
    OP_LDB_S         = 4'b0010,
    OP_LDH_S         = 4'b0011,
    OP_LDH_U_IMM     = 4'b0100,
    OP_SHL_IMM       = 4'b0101,
    OP_SHR_IMM       = 4'b0110,
    OP_SHL_REG       = 4'b0111,
    OP_SHR_REG       = 4'b1000,
    OP_REGISTER_COPY = 4'b1001
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [2:0] dst;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic [4:0] imm;
  } dec_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
  } mem_req_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } flags_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_MEM   = 2'b10
  } state_t;

endpackage : hsl_pkg

// ===== rtl/instr_group_decoder.sv
/*
  Combinational decoder of one 16-bit instruction into the group's operation
  and register fields. Assumes the instruction is stable while it is read.
*/
`timescale 1ns/1ns
`include "hsl_cfg.svh"

module instr_group_decoder
  import hsl_pkg::*;
(
  // instruction in
  input  wire logic [15:0]   instr,
  // decoded fields
  output hsl_pkg::dec_t      dec
);

  always_comb
  begin
    dec       = '0;
    dec.op    = OP_NONE;
    dec.dst   = instr[`FLD_LOW];
    dec.src_a = instr[`FLD_MID];
    dec.src_b = instr[`FLD_OFS];
    dec.imm   = instr[`FLD_FIVE_BIT_IMMEDIATE];
    // register shifts first: their opcode lies inside no other pattern
    if (instr[`OPC10_FLD] == `OPC10_SHL_REG || instr[`OPC10_FLD] == `OPC10_SHR_REG)
    begin
      dec.op    = (instr[`OPC10_FLD] == `OPC10_SHL_REG) ? OP_SHL_REG : OP_SHR_REG;
      dec.src_a = instr[`FLD_LOW];
      dec.src_b = instr[`FLD_MID];
    end
    else if (instr[`OPC7_FLD] == `OPC7_LDH_U_REG)
      dec.op = OP_LDH_U_REG;
    else if (instr[`OPC7_FLD] == `OPC7_LDB_S)
      dec.op = OP_LDB_S;
    else if (instr[`OPC7_FLD] == `OPC7_LDH_S)
      dec.op = OP_LDH_S;
    else if (instr[`OPC5_FLD] == `OPC5_LDH_U_IMM)
      dec.op = OP_LDH_U_IMM;
    else if (instr[`OPC5_FLD] == `OPC5_SHL_IMM)
      dec.op = (instr[`FLD_FIVE_BIT_IMMEDIATE] == `IMM_ZERO) ? OP_REGISTER_COPY : OP_SHL_IMM;
    else if (instr[`OPC5_FLD] == `OPC5_SHR_IMM)
      dec.op = OP_SHR_IMM;
  end

endmodule : instr_group_decoder

// ===== rtl/logical_shifter.sv
/*
  Logical shifter with carry-out for counts 0 to 255. Purely combinational;
  assumes the caller supplies the current carry for the zero-count case.
*/
`timescale 1ns/1ns
`include "hsl_cfg.svh"

module logical_shifter
(
  // operands
  input  wire logic [31:0]   value,
  input  wire logic [7:0]    count,
  input  wire logic          right,
  input  wire logic          carry_in,
  // result
  output logic      [31:0]   result,
  output logic               carry
);

  logic [32:0] left_ext;
  logic [32:0] right_ext;

  // one spare bit catches the last bit out; counts past 32 clear everything
  assign left_ext  = {1'b0, value} << count;
  assign right_ext = {value, 1'b0} >> count;

  always_comb
  begin
    result = value;
    carry  = carry_in;
    if (count != `COUNT_ZERO)
    begin
      result = right ? right_ext[32:1] : left_ext[31:0];
      carry  = right ? right_ext[0] : left_ext[32];
    end
  end

endmodule : logical_shifter

// ===== verif/core_side_model.sv
/*
  Behavioural far side of the load/shift sequencer: an eight-entry register
  file with combinational read, and a data memory that answers each read
  request after a chosen latency. Assumes one clock, and that the bench
  preloads registers only while no instruction is in flight.
*/
`timescale 1ns/1ns

module core_side_model
  import hsl_pkg::*;
(
  // clock
  input  wire logic              clk_sys,
  // bench control
  input  wire logic              pre_en,
  input  wire logic [2:0]        pre_idx,
  input  wire logic [31:0]       pre_data,
  input  wire logic [3:0]        lat,
  // register file
  input  wire logic [2:0]        rf_rd_a_idx,
  input  wire logic [2:0]        rf_rd_b_idx,
  output logic      [31:0]       rf_rd_a_data,
  output logic      [31:0]       rf_rd_b_data,
  input  wire logic              rf_wr_en,
  input  wire logic [2:0]        rf_wr_idx,
  input  wire logic [31:0]       rf_wr_data,
  // data memory
  input  wire logic              mem_req,
  input  wire hsl_pkg::mem_req_t mem_cmd,
  output logic                   mem_rvalid,
  output logic      [15:0]       mem_rdata
);
  logic [31:0] regs [8];
  logic [31:0] hold_addr;
  logic [3:0]  wait_cnt;

  initial
  begin
    for (int i = 0; i < 8; i++)
      regs[i] = 32'h00000000;
    mem_rvalid = 1'b0;
    mem_rdata  = 16'h0000;
    wait_cnt   = 4'h0;
    hold_addr  = 32'h00000000;
  end

  assign rf_rd_a_data = regs[rf_rd_a_idx];
  assign rf_rd_b_data = regs[rf_rd_b_idx];

  always @(posedge clk_sys)
  begin
    if (pre_en)
      regs[pre_idx] <= pre_data;
    if (rf_wr_en)
      regs[rf_wr_idx] <= rf_wr_data;
  end

  // outside an answer the data lines toggle, so stale data never looks valid
  always @(posedge clk_sys)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (mem_req && lat == 4'h0)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= {mem_cmd.addr[7:0], mem_cmd.addr[7:0]} ^ 16'h8080;
    end
    else if (mem_req)
    begin
      hold_addr <= mem_cmd.addr;
      wait_cnt  <= lat;
    end
    else if (wait_cnt != 4'h0)
    begin
      wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h1)
      begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= {hold_addr[7:0], hold_addr[7:0]} ^ 16'h8080;
      end
    end
  end
endmodule : core_side_model

// ===== verif/tb.sv
/*
  Self-checking bench of the load/shift sequencer. Each scenario task offers
  instructions, watches the register write, flag write and memory request,
  and compares against hand-worked values. Assumes core_side_model beside it.
*/
`timescale 1ns/1ns
`include "hsl_cfg.svh"

module tb;
  import hsl_pkg::*;
  logic              clk_sys, rst_n, instr_valid, in_predicated_group, carry_now;
  logic [15:0]       instr, mem_rdata;
  logic              instr_ready, copy_redirect, not_in_group, rf_wr_en, flags_wr_en;
  logic [2:0]        rf_rd_a_idx, rf_rd_b_idx, rf_wr_idx, pre_idx;
  logic [31:0]       rf_rd_a_data, rf_rd_b_data, rf_wr_data, pre_data;
  logic              mem_req, mem_rvalid, pre_en;
  logic [3:0]        lat;
  flags_t            status_flags, s_fl;
  mem_req_t          mem_cmd;
  int                failures, samples_checked, cycles, s_k;
  logic [31:0]       s_data, s_addr;
  logic [2:0]        s_idx;
  logic [1:0]        s_size;
  logic              s_fw, s_cp, s_ng;

  half_signed_load_shift_exec #(.DATA_W(32)) half_signed_load_shift_exec_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .in_predicated_group(in_predicated_group), .instr_ready(instr_ready),
    .copy_redirect(copy_redirect), .not_in_group(not_in_group),
    .rf_rd_a_idx(rf_rd_a_idx), .rf_rd_b_idx(rf_rd_b_idx), .rf_rd_a_data(rf_rd_a_data),
    .rf_rd_b_data(rf_rd_b_data), .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx),
    .rf_wr_data(rf_wr_data), .carry_now(carry_now), .flags_wr_en(flags_wr_en),
    .status_flags(status_flags), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  core_side_model core_side_model_inst (
    .clk_sys(clk_sys), .pre_en(pre_en), .pre_idx(pre_idx), .pre_data(pre_data),
    .lat(lat), .rf_rd_a_idx(rf_rd_a_idx), .rf_rd_b_idx(rf_rd_b_idx),
    .rf_rd_a_data(rf_rd_a_data), .rf_rd_b_data(rf_rd_b_data), .rf_wr_en(rf_wr_en),
    .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // --------------------------------------------------------------------------
  // clock, report and shared tasks
  // --------------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic pre(input logic [2:0] idx, input logic [31:0] val);
    @(posedge clk_sys);
    pre_en   <= 1'b1;
    pre_idx  <= idx;
    pre_data <= val;
    @(posedge clk_sys);
    pre_en   <= 1'b0;
  endtask : pre

  // offers one word, then records what comes back until the first write or pulse
  task automatic go(input logic [15:0] w, input logic pr);
    int k;
    @(posedge clk_sys);
    instr_valid         <= 1'b1;
    instr               <= w;
    in_predicated_group <= pr;
    k = 0;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && k < 20)
    begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    s_k = 0;
    s_size = 2'bxx;
    for (k = 1; k < 30 && s_k == 0; k++)
    begin
      @(negedge clk_sys);
      if (mem_req === 1'b1)
        {s_addr, s_size} = {mem_cmd.addr, mem_cmd.size};
      s_cp = copy_redirect;
      s_ng = not_in_group;
      {s_idx, s_data, s_fw, s_fl} = {rf_wr_idx, rf_wr_data, flags_wr_en, status_flags};
      if (rf_wr_en === 1'b1 || s_cp === 1'b1 || s_ng === 1'b1)
        s_k = k;
    end
  endtask : go

  task automatic chk_ld(input logic [2:0] t, input logic [31:0] d, input logic [31:0] a,
                        input logic [1:0] sz);
    chk("load address", s_addr, a);
    chk("load size", 32'(s_size), 32'(sz));
    chk("load target", 32'(s_idx), 32'(t));
    chk("load data", s_data, d);
    chk("base kept", core_side_model_inst.regs[2], 32'h20000000);
  endtask : chk_ld

  task automatic chk_sh(input logic [31:0] d, input logic [2:0] f, input logic fw);
    chk("shift cycle", 32'(s_k), 32'd2);
    chk("shift dest", 32'(s_idx), 32'h5);
    chk("shift data", s_data, d);
    chk("flag write", 32'(s_fw), 32'(fw));
    if (fw)
      chk("flags", 32'(s_fl), 32'(f));
  endtask : chk_sh

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_loads();
    lat = 4'h0;
    go(16'h5A53, 1'b0);
    chk_ld(3'h3, 32'h00009090, 32'h20000010, `SIZE_HALF);
    lat = 4'h5;
    go(16'h5653, 1'b0);
    chk_ld(3'h3, 32'hFFFFFF90, 32'h20000010, `SIZE_BYTE);
    go(16'h5E53, 1'b0);
    chk_ld(3'h3, 32'hFFFF9090, 32'h20000010, `SIZE_HALF);
  endtask : t_loads

  task automatic t_load_imm();
    lat = 4'h1;
    // target 7 keeps the shift operand in register 4 intact for later scenarios
    go(16'h8FD7, 1'b0);
    chk_ld(3'h7, 32'h0000BEBE, 32'h2000003E, `SIZE_HALF);
  endtask : t_load_imm

  task automatic t_copy_other();
    go(16'h0025, 1'b0);
    chk("copy pulse", 32'(s_cp), 32'h1);
    chk("copy no write", 32'(rf_wr_en), 32'h0);
    chk("copy cycle", 32'(s_k), 32'h1);
    go(16'hBF00, 1'b0);
    chk("other pulse", 32'(s_ng), 32'h1);
  endtask : t_copy_other

  task automatic t_shift_imm();
    go(16'h0065, 1'b0);
    chk_sh(32'h00000002, 3'b001, 1'b1);
    go(16'h07E5, 1'b0);
    chk_sh(32'h80000000, 3'b100, 1'b1);
    go(16'h0825, 1'b0);
    chk_sh(32'h00000000, 3'b011, 1'b1);
    go(16'h0865, 1'b0);
    chk_sh(32'h40000000, 3'b001, 1'b1);
  endtask : t_shift_imm

  task automatic t_shift_reg();
    pre(3'h5, 32'h00000003);
    pre(3'h6, 32'hFFFFFF20);
    go(16'h40B5, 1'b0);
    chk_sh(32'h00000000, 3'b011, 1'b1);
    pre(3'h5, 32'h80000000);
    pre(3'h6, 32'hFFFFFF00);
    carry_now <= 1'b1;
    go(16'h40B5, 1'b0);
    chk_sh(32'h80000000, 3'b101, 1'b1);
    pre(3'h5, 32'h00000003);
    pre(3'h6, 32'h00000021);
    carry_now <= 1'b0;
    go(16'h40B5, 1'b0);
    chk_sh(32'h00000000, 3'b010, 1'b1);
    pre(3'h5, 32'h0000000C);
    pre(3'h6, 32'hFFFFFF02);
    go(16'h40F5, 1'b0);
    chk_sh(32'h00000003, 3'b000, 1'b1);
  endtask : t_shift_reg

  task automatic t_pred();
    go(16'h0065, 1'b1);
    chk_sh(32'h00000002, 3'b001, 1'b0);
  endtask : t_pred

  initial
  begin
    {rst_n, instr_valid, in_predicated_group, carry_now, pre_en} = 5'b00000;
    {instr, pre_idx, pre_data, lat} = '0;
    {failures, samples_checked, cycles} = '0;
    pre(3'h1, 32'h00000010);
    pre(3'h2, 32'h20000000);
    pre(3'h4, 32'h80000001);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ready in reset", 32'(instr_ready), 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_loads();
    t_load_imm();
    t_copy_other();
    t_shift_imm();
    t_shift_reg();
    t_pred();
    end_of_test();
  end
endmodule : tb
